//--- hw/sss_top.sv
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "sss_cfg.svh"

// Operation
// - Clocked, master, port on; receive enables pick direction
// - Slave transmit equals master transmit timing
// - First word loads shifter, second waits, flag clear
// - After shift-out, held word loads, flag sets
// - Transmit flag wakes when both enables set
// - Slave receive ignores single receive enable
// - Sleep reception fills receive data register
// - Only slave mode shifts during sleep
// - Slave shifters run from external clock line
// - Receive flag sets on complete word
// - Wake continues; global enable calls fixed vector
// - Receive flag on completion, request if enabled
// - Clearing continuous receive or port clears overrun
// - Continuous enable starts; ninth bit from status
// - Slave releases clock driver; leading change, trailing sample
// - Two-character buffer; third sets overrun, blocks reception
// - Polarity bit picks clock idle level
module sss_top
#(
    parameter int DIVW = 16
)
(
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic [7:0]  addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [7:0]  rdata,
    input  wire logic        sleep,
    input  wire logic        ck_in,
    output logic             ck_out,
    output logic             ck_oe,
    input  wire logic        dt_in,
    output logic             dt_out,
    output logic             dt_oe,
    output logic             wake,
    output logic             irq,
    output logic      [15:0] irq_vector
);
    import sss_pkg::*;

    // Software registers
    logic [7:0]      txctl_q;
    logic [7:0]      rxctl_q;
    logic            ck_pol_q;
    logic [DIVW-1:0] div_q;
    logic [3:0]      inten_q;
    logic [7:0]      rdata_q;

    // Transmit path
    logic [7:0]      thr_q;
    logic            thr_full_q;
    sss_char_t       tx_shift_q;
    logic [3:0]      tx_cnt_q;
    logic            dt_out_q;

    // Receive path
    sss_char_t       rx_shift_q;
    logic [3:0]      rx_cnt_q;
    logic            ovr_q;
    logic            ck_prev_q;
    logic            wake_q;
    logic            irq_q;

    // Address decode
    logic wr_txctl;
    logic wr_rxctl;
    logic wr_baud;
    logic wr_divlo;
    logic wr_divhi;
    logic wr_txdata;
    logic wr_inten;
    logic rd_rxdata;

    assign wr_txctl  = wr & (addr == `SSS_OFS_TXCTL);
    assign wr_rxctl  = wr & (addr == `SSS_OFS_RXCTL);
    assign wr_baud   = wr & (addr == `SSS_OFS_BAUDCTL);
    assign wr_divlo  = wr & (addr == `SSS_OFS_DIVLO);
    assign wr_divhi  = wr & (addr == `SSS_OFS_DIVHI);
    assign wr_txdata = wr & (addr == `SSS_OFS_TXDATA);
    assign wr_inten  = wr & (addr == `SSS_OFS_INTEN);
    assign rd_rxdata = rd & (addr == `SSS_OFS_RXDATA);

    // Field views
    logic is_master;
    logic tx_nine;
    logic tx_en;
    logic sync_sel;
    logic tx_bit8;
    logic port_en;
    logic rx_nine;
    logic rx_single;
    logic rx_cont;
    logic port_on;

    assign is_master = txctl_q[`SSS_TXC_MASTER];
    assign tx_nine   = txctl_q[`SSS_TXC_NINE];
    assign tx_en     = txctl_q[`SSS_TXC_EN];
    assign sync_sel  = txctl_q[`SSS_TXC_SYNC];
    assign tx_bit8   = txctl_q[`SSS_TXC_BIT8];
    assign port_en   = rxctl_q[`SSS_RXC_PORT];
    assign rx_nine   = rxctl_q[`SSS_RXC_NINE];
    assign rx_single = rxctl_q[`SSS_RXC_SINGLE];
    assign rx_cont   = rxctl_q[`SSS_RXC_CONT];
    assign port_on   = port_en & sync_sel;

    // Mode decode
    sss_mode_t mode;
    logic      slave_sel;

    assign slave_sel = port_on & ~is_master;
    assign mode = !port_on ? SSS_OFF :
                  is_master ? ((rx_single | rx_cont) ? SSS_MRX : SSS_MTX) :
                  (rx_cont ? SSS_SRX : SSS_STX);

    logic tx_mode;
    logic tx_go;
    logic rx_on;

    assign tx_mode = (mode == SSS_MTX) | (mode == SSS_STX);
    assign tx_go   = tx_mode & tx_en;
    assign rx_on   = ((mode == SSS_MRX) | (mode == SSS_SRX)) & ~ovr_q;

    // Bit clock edges
    logic tx_busy;
    logic gen_run;
    logic gen_ck;
    logic gen_lead;
    logic gen_trail;
    logic s_lead;
    logic s_trail;
    logic lead;
    logic trail;

    assign tx_busy = (tx_cnt_q != 4'h0);
    // Internal clock needs the system clock, so sleep stops it
    assign gen_run = ~sleep & ((mode == SSS_MTX & tx_busy) | (mode == SSS_MRX & ~ovr_q));

    sss_clk_gen #(
        .DIVW     (DIVW)
    ) u_clk_gen (
        .mclk     (mclk),
        .rstn     (rstn),
        .run      (gen_run),
        .div      (div_q),
        .idle_lvl (ck_pol_q),
        .ck_q     (gen_ck),
        .lead     (gen_lead),
        .trail    (gen_trail)
    );

    // Leading edge leaves the idle level, trailing edge returns to it
    assign s_lead  = slave_sel & (ck_in != ck_prev_q) & (ck_prev_q == ck_pol_q);
    assign s_trail = slave_sel & (ck_in != ck_prev_q) & (ck_prev_q != ck_pol_q);
    assign lead    = is_master ? gen_lead : s_lead;
    assign trail   = is_master ? gen_trail : s_trail;

    // Pin drivers
    assign ck_out = gen_ck;
    assign ck_oe  = port_on & is_master;
    assign dt_out = dt_out_q;
    assign dt_oe  = tx_go;

    // Transmit hand-off
    logic tx_load;

    assign tx_load = tx_go & thr_full_q & ~tx_busy;

    // Receive completion
    logic [3:0] rx_bits;
    logic       rx_done;
    logic       fifo_empty;
    logic       fifo_full;
    logic       fifo_push;
    logic       ovr_set;
    logic       ovr_clr;
    sss_char_t  rx_word;
    sss_char_t  fifo_head;

    function automatic sss_char_t put_bit(input sss_char_t w,
                                          input logic [3:0] i,
                                          input logic b);
        sss_char_t r;
        r = w;
        r[i] = b;
        return r;
    endfunction

    assign rx_bits   = sss_char_bits(rx_nine);
    assign rx_word   = put_bit(rx_shift_q, rx_cnt_q, dt_in);
    assign rx_done   = rx_on & trail & (4'(rx_cnt_q + 4'h1) == rx_bits);
    assign fifo_push = rx_done & ~fifo_full;
    assign ovr_set   = rx_done & fifo_full;
    assign ovr_clr   = (wr_rxctl & ~wdata[`SSS_RXC_CONT] & rx_cont)
                     | (rd_rxdata & ~rx_cont);

    // Clearing the port enable empties the buffer too
    sss_rx_fifo #(
        .DEPTH (`SSS_FIFO_DEPTH)
    ) u_rx_fifo (
        .mclk  (mclk),
        .rstn  (rstn),
        .clr   (~port_en),
        .push  (fifo_push),
        .din   (rx_word),
        .pop   (rd_rxdata),
        .dout  (fifo_head),
        .empty (fifo_empty),
        .full  (fifo_full)
    );

    // Flags and wake
    logic rx_flag;
    logic tx_flag;
    logic rx_ie;
    logic tx_ie;
    logic per_ie;
    logic glb_ie;
    logic wake_d;

    assign rx_flag = ~fifo_empty;
    assign tx_flag = tx_en & ~thr_full_q;
    assign rx_ie   = inten_q[`SSS_IE_RX];
    assign tx_ie   = inten_q[`SSS_IE_TX];
    assign per_ie  = inten_q[`SSS_IE_PER];
    assign glb_ie  = inten_q[`SSS_IE_GLB];
    assign wake_d  = per_ie & ((rx_ie & rx_flag) | (tx_ie & tx_flag));

    assign wake       = wake_q;
    assign irq        = irq_q;
    assign irq_vector = `SSS_VECTOR;

    // Read data
    logic [7:0] rd_val;

    assign rd_val =
        (addr == `SSS_OFS_TXCTL)   ? {txctl_q[7:4], 2'b00, ~tx_busy, tx_bit8} :
        (addr == `SSS_OFS_RXCTL)   ? {rxctl_q[7:4], 2'b00, ovr_q, fifo_head[8]} :
        (addr == `SSS_OFS_BAUDCTL) ? {3'b000, ck_pol_q, 4'h0} :
        (addr == `SSS_OFS_DIVLO)   ? div_q[7:0] :
        (addr == `SSS_OFS_DIVHI)   ? 8'(div_q >> 8) :
        (addr == `SSS_OFS_RXDATA)  ? fifo_head[7:0] :
        (addr == `SSS_OFS_INTEN)   ? {4'h0, inten_q} :
        (addr == `SSS_OFS_INTFLAG) ? {6'b000000, tx_flag, rx_flag} :
        8'h00;

    assign rdata = rdata_q;

    always_ff @(posedge mclk)
    begin
        if (!rstn)
            rdata_q <= 8'h00;
        else
            rdata_q <= rd ? rd_val : 8'h00;
    end

    // Control registers
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            txctl_q  <= `SSS_CTL_RST;
            ck_pol_q <= 1'b0;
            div_q    <= DIVW'(`SSS_DIV_RST);
            inten_q  <= 4'h0;
        end
        else
        begin
            if (wr_txctl)
                txctl_q <= {wdata[7:4], 3'b000, wdata[`SSS_TXC_BIT8]};
            if (wr_baud)
                ck_pol_q <= wdata[`SSS_BAUD_POL];
            if (wr_divlo)
                div_q <= {div_q[DIVW-1:8], wdata};
            if (wr_divhi)
                div_q <= {DIVW'(wdata) << 8} | {{(DIVW-8){1'b0}}, div_q[7:0]};
            if (wr_inten)
                inten_q <= wdata[3:0];
        end
    end

    // Single receive drops after one character, master only
    always_ff @(posedge mclk)
    begin
        if (!rstn)
            rxctl_q <= `SSS_CTL_RST;
        else if (wr_rxctl)
            rxctl_q <= {wdata[7:4], 4'h0};
        else if (rx_done && is_master)
            rxctl_q[`SSS_RXC_SINGLE] <= 1'b0;
    end

    // Overrun; a new overrun beats a clear in the same cycle
    always_ff @(posedge mclk)
    begin
        if (!rstn || !port_en)
            ovr_q <= 1'b0;
        else if (ovr_set)
            ovr_q <= 1'b1;
        else if (ovr_clr)
            ovr_q <= 1'b0;
    end

    // Holding register
    always_ff @(posedge mclk)
    begin
        if (!rstn || !port_en)
        begin
            thr_q      <= 8'h00;
            thr_full_q <= 1'b0;
        end
        else if (wr_txdata)
        begin
            thr_q      <= wdata;
            thr_full_q <= 1'b1;
        end
        else if (tx_load)
            thr_full_q <= 1'b0;
    end

    // Transmit shifter: change on leading edge, count on trailing
    always_ff @(posedge mclk)
    begin
        if (!rstn || !port_en)
        begin
            tx_shift_q <= '0;
            tx_cnt_q   <= 4'h0;
            dt_out_q   <= 1'b0;
        end
        else if (tx_load)
        begin
            tx_shift_q <= {tx_nine & tx_bit8, thr_q};
            tx_cnt_q   <= sss_char_bits(tx_nine);
        end
        else if (tx_busy && lead)
        begin
            dt_out_q   <= tx_shift_q[0];
            tx_shift_q <= tx_shift_q >> 1;
        end
        else if (tx_busy && trail)
            tx_cnt_q <= tx_cnt_q - 4'h1;
    end

    // Receive shifter samples on trailing edge; partial char dropped
    always_ff @(posedge mclk)
    begin
        if (!rstn || !rx_on)
        begin
            rx_shift_q <= '0;
            rx_cnt_q   <= 4'h0;
        end
        else if (rx_done)
        begin
            rx_shift_q <= '0;
            rx_cnt_q   <= 4'h0;
        end
        else if (trail)
        begin
            rx_shift_q <= rx_word;
            rx_cnt_q   <= rx_cnt_q + 4'h1;
        end
    end

    // Clock line history and wake outputs
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            ck_prev_q <= 1'b0;
            wake_q    <= 1'b0;
            irq_q     <= 1'b0;
        end
        else
        begin
            ck_prev_q <= slave_sel ? ck_in : ck_pol_q;
            wake_q    <= wake_d;
            irq_q     <= wake_d & glb_ie;
        end
    end

endmodule

//--- hw/sss_cfg.svh
`ifndef SSS_CFG_SVH
`define SSS_CFG_SVH

// Register offsets
`define SSS_OFS_TXCTL    8'h00
`define SSS_OFS_RXCTL    8'h04
`define SSS_OFS_BAUDCTL  8'h08
`define SSS_OFS_DIVLO    8'h0C
`define SSS_OFS_DIVHI    8'h10
`define SSS_OFS_TXDATA   8'h14
`define SSS_OFS_RXDATA   8'h18
`define SSS_OFS_INTEN    8'h1C
`define SSS_OFS_INTFLAG  8'h20

// Transmit control fields
`define SSS_TXC_MASTER   7
`define SSS_TXC_NINE     6
`define SSS_TXC_EN       5
`define SSS_TXC_SYNC     4
`define SSS_TXC_EMPTY    1
`define SSS_TXC_BIT8     0

// Receive control fields
`define SSS_RXC_PORT     7
`define SSS_RXC_NINE     6
`define SSS_RXC_SINGLE   5
`define SSS_RXC_CONT     4
`define SSS_RXC_OVR      1
`define SSS_RXC_BIT8     0

// Baud control, interrupt enable and flag fields
`define SSS_BAUD_POL     4
`define SSS_IE_RX        0
`define SSS_IE_TX        1
`define SSS_IE_PER       2
`define SSS_IE_GLB       3
`define SSS_IF_RX        0
`define SSS_IF_TX        1

// Reset values, sizes, vector
`define SSS_CTL_RST      8'h00
`define SSS_DIV_RST      16'h0000
`define SSS_FIFO_DEPTH   2
`define SSS_BITS_8       4'h8
`define SSS_BITS_9       4'h9
`define SSS_VECTOR       16'h0004

`endif

//--- hw/sss_pkg.sv
package sss_pkg;

    typedef logic [8:0] sss_char_t;

    typedef enum logic [4:0]
    {
        SSS_OFF = 5'b00001,
        SSS_MTX = 5'b00010,
        SSS_MRX = 5'b00100,
        SSS_STX = 5'b01000,
        SSS_SRX = 5'b10000
    } sss_mode_t;

    function automatic logic [3:0] sss_char_bits(input logic nine);
        return nine ? 4'h9 : 4'h8;
    endfunction

endpackage

//--- hw/sss_rx_fifo.sv
`timescale 1ns/1ps
`include "sss_cfg.svh"

module sss_rx_fifo
#(
    parameter int DEPTH = `SSS_FIFO_DEPTH
)
(
    input  wire logic               mclk,
    input  wire logic               rstn,
    input  wire logic               clr,
    input  wire logic               push,
    input  wire sss_pkg::sss_char_t din,
    input  wire logic               pop,
    output sss_pkg::sss_char_t      dout,
    output logic                    empty,
    output logic                    full
);
    import sss_pkg::*;

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    sss_char_t     mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0]   cnt_q;
    logic          do_push;
    logic          do_pop;

    function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
    endfunction

    assign empty   = (cnt_q == '0);
    assign full    = (cnt_q == (AW+1)'(DEPTH));
    assign do_push = push & ~full;
    assign do_pop  = pop & ~empty;
    assign dout    = mem_q[rd_q];

    always_ff @(posedge mclk)
    begin
        if (!rstn || clr)
        begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (do_push)
                wr_q <= nxt(wr_q);
            if (do_pop)
                rd_q <= nxt(rd_q);
            cnt_q <= (AW+1)'(cnt_q + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop});
        end
    end

    // Storage needs no reset; the count guards it
    always_ff @(posedge mclk)
    begin
        if (do_push)
            mem_q[wr_q] <= din;
    end

endmodule

//--- hw/sss_clk_gen.sv
`timescale 1ns/1ps
`include "sss_cfg.svh"

module sss_clk_gen
#(
    parameter int DIVW = 16
)
(
    input  wire logic            mclk,
    input  wire logic            rstn,
    input  wire logic            run,
    input  wire logic [DIVW-1:0] div,
    input  wire logic            idle_lvl,
    output logic                 ck_q,
    output logic                 lead,
    output logic                 trail
);
    import sss_pkg::*;

    logic [DIVW-1:0] cnt_q;
    logic            act_q;
    logic            tick;

    assign tick  = run & (cnt_q == div);
    assign lead  = tick & ~act_q;
    assign trail = tick & act_q;

    // Stopping drops the line straight to idle, so no stray half cycle
    always_ff @(posedge mclk)
    begin
        if (!rstn || !run)
        begin
            cnt_q <= '0;
            act_q <= 1'b0;
            ck_q  <= idle_lvl;
        end
        else if (tick)
        begin
            cnt_q <= '0;
            act_q <= ~act_q;
            ck_q  <= act_q ? idle_lvl : ~idle_lvl;
        end
        else
        begin
            cnt_q <= DIVW'(cnt_q + 1'b1);
        end
    end

endmodule

//--- dv/sss_top_checker.sv
`timescale 1ns/1ps
module sss_top_checker
(
    input wire logic        mclk,
    input wire logic        rstn,
    input wire logic [7:0]  addr,
    input wire logic [7:0]  wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [7:0]  rdata,
    input wire logic        sleep,
    input wire logic        ck_in,
    input wire logic        ck_out,
    input wire logic        ck_oe,
    input wire logic        dt_in,
    input wire logic        dt_out,
    input wire logic        dt_oe,
    input wire logic        wake,
    input wire logic        irq,
    input wire logic [15:0] irq_vector
);
    logic [7:0] tx_q;
    logic [7:0] rx_q;
    logic [7:0] ie_q;
    logic [5:0] ck_hist_q;
    // Wide window: data moves one cycle after the clock edge is seen
    wire        ck_moved = ({ck_hist_q, ck_in} != 7'h00) && ({ck_hist_q, ck_in} != 7'h7F);

    always_ff @(posedge mclk)
    begin
        ck_hist_q <= {ck_hist_q[4:0], ck_in};
        if (!rstn)
        begin
            tx_q <= 8'h00;
            rx_q <= 8'h00;
            ie_q <= 8'h00;
        end
        else if (wr && addr == 8'h00)
            tx_q <= wdata;
        else if (wr && addr == 8'h04)
            rx_q <= wdata;
        else if (wr && addr == 8'h1C)
            ie_q <= wdata;
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    sequence s_slave_shift;
        dt_oe && $past(dt_oe) && !tx_q[7] && $changed(dt_out);
    endsequence
    sequence s_master_asleep;
        // First sleep cycle may still drop the clock to idle
        (sleep && tx_q[7] && tx_q[4] && rx_q[7]) [*3];
    endsequence

    property p_vector;
        irq_vector == 16'h0004;
    endproperty
    property p_irq_wake;
        irq |-> wake;
    endproperty
    property p_rdata_idle;
        !rd |=> rdata == 8'h00;
    endproperty
    property p_ck_driver;
        ck_oe == (tx_q[7] && tx_q[4] && rx_q[7]);
    endproperty
    property p_dt_driver;
        dt_oe |-> rx_q[7] && tx_q[5] && !rx_q[4];
    endproperty
    property p_single_ignored;
        rx_q[7] && tx_q[4] && tx_q[5] && !tx_q[7] && !rx_q[4] |-> dt_oe;
    endproperty
    property p_dt_follows_ck;
        s_slave_shift |-> ck_moved;
    endproperty
    property p_wake_per;
        wake |-> $past(ie_q[2]);
    endproperty
    property p_irq_glb;
        irq |-> $past(ie_q[3]);
    endproperty
    property p_sleep_ck;
        s_master_asleep |-> $stable(ck_out);
    endproperty

    a_vector: assert property (p_vector) else $error("vector not fixed");
    a_irq_wake: assert property (p_irq_wake) else $error("irq without wake");
    a_rdata_idle: assert property (p_rdata_idle) else $error("rdata without read");
    a_ck_driver: assert property (p_ck_driver) else $error("clock driver wrong");
    a_dt_driver: assert property (p_dt_driver) else $error("data driver wrong");
    a_single_ignored: assert property (p_single_ignored) else $error("single rx used");
    a_dt_follows_ck: assert property (p_dt_follows_ck) else $error("data moved alone");
    a_wake_per: assert property (p_wake_per) else $error("wake without enable");
    a_irq_glb: assert property (p_irq_glb) else $error("irq without global");
    a_sleep_ck: assert property (p_sleep_ck) else $error("master clock in sleep");
endmodule

bind sss_top sss_top_checker sss_top_checker_i (.mclk(mclk), .rstn(rstn), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .sleep(sleep), .ck_in(ck_in),
    .ck_out(ck_out), .ck_oe(ck_oe), .dt_in(dt_in), .dt_out(dt_out), .dt_oe(dt_oe),
    .wake(wake), .irq(irq), .irq_vector(irq_vector));

//--- dv/sss_ext_master.sv
`timescale 1ns/1ps
module sss_ext_master
#(
    parameter int HALF = 4
)
(
    input wire logic       mclk,
    input wire logic       go,
    input wire logic [8:0] word,
    input wire logic [3:0] nbits,
    input wire logic       pol,
    input wire logic       drive,
    input wire logic       dt_line,
    output logic           ck,
    output logic           dt,
    output logic           dt_en,
    output logic [8:0]     rx,
    output logic           busy
);
    initial
    begin
        ck = 1'b0;
        dt = 1'b0;
        dt_en = 1'b0;
        rx = 9'h000;
        busy = 1'b0;
    end

    always
    begin
        @(posedge mclk);
        while (!go)
        begin
            ck <= pol;
            @(posedge mclk);
        end
        busy <= 1'b1;
        dt_en <= drive;
        rx <= 9'h000;
        for (int i = 0; i < nbits; i++)
        begin
            repeat (HALF) @(posedge mclk);
            ck <= ~pol;
            dt <= word[i];
            repeat (HALF) @(posedge mclk);
            rx[i] <= dt_line;
            ck <= pol;
        end
        repeat (HALF) @(posedge mclk);
        dt_en <= 1'b0;
        // Released line shows no stale bit
        dt <= ~dt;
        busy <= 1'b0;
    end
endmodule

//--- dv/testbench.sv
`timescale 1ns/1ps
module testbench;
    import sss_pkg::*;
    logic        mclk, rstn, wr, rd, sleep, m_go, m_pol, m_drive;
    logic [7:0]  addr, wdata, rdata, t0, t1;
    logic        ck_out, ck_oe, dt_out, dt_oe, wake, irq, m_ck, m_dt, m_dt_en, m_busy;
    logic [15:0] irq_vector, lfsr_q;
    logic [8:0]  m_word, m_rx, w;
    logic [3:0]  m_bits;
    int          mismatches, samples_checked, cycles;
    int          exp_q[$];
    wire         ck_w = ck_oe ? ck_out : m_ck;
    wire         dt_w = dt_oe ? dt_out : m_dt;

    sss_top #(.DIVW(16)) sss_top_i (.mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .sleep(sleep), .ck_in(ck_w), .ck_out(ck_out),
        .ck_oe(ck_oe), .dt_in(dt_w), .dt_out(dt_out), .dt_oe(dt_oe), .wake(wake), .irq(irq),
        .irq_vector(irq_vector));
    sss_ext_master #(.HALF(4)) sss_ext_master_i (.mclk(mclk), .go(m_go), .word(m_word),
        .nbits(m_bits), .pol(m_pol), .drive(m_drive), .dt_line(dt_w), .ck(m_ck), .dt(m_dt),
        .dt_en(m_dt_en), .rx(m_rx), .busy(m_busy));

    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            mismatches++;
            report_and_stop();
        end
    end

    task automatic rnd;
        lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
        w = lfsr_q[8:0];
    endtask
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string name);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        chk(name, {8'h00, rdata}, {8'h00, exp});
    endtask
    // Far side clocks one character; bounded waits
    task automatic frame(input logic [8:0] v, input logic [3:0] n, input logic drv);
        int k;
        @(posedge mclk);
        m_word <= v;
        m_bits <= n;
        m_drive <= drv;
        m_go <= 1'b1;
        @(posedge mclk);
        m_go <= 1'b0;
        k = 0;
        while ((!m_busy && k < 10) || (m_busy && k < 400))
        begin
            @(posedge mclk);
            k++;
        end
    endtask
    task automatic wait_wake;
        int k;
        k = 0;
        while (wake !== 1'b1 && k < 20)
        begin
            @(posedge mclk);
            #1;
            k++;
        end
    endtask

    initial
    begin
        {rstn, addr, wdata, wr, rd, sleep, m_go, m_pol, m_drive, m_word} = '0;
        m_bits = 4'h8;
        mismatches = 0;
        samples_checked = 0;
        cycles = 0;
        lfsr_q = 16'h89DD;
        repeat (8) @(posedge mclk);
        rstn <= 1'b1;
        rd_chk(8'h00, 8'h02, "txctl reset");
        rd_chk(8'h04, 8'h00, "rxctl reset");
        rd_chk(8'h20, 8'h00, "flags reset");
        chk("vector", irq_vector, 16'h0004);
        wr_reg(8'h30, 8'hFF);
        rd_chk(8'h30, 8'h00, "unmapped");
        // Slave receive across sleep, then overrun
        wr_reg(8'h00, 8'h10);
        wr_reg(8'h04, 8'h90);
        wr_reg(8'h1C, 8'h0D);
        sleep <= 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            rnd();
            if (i < 2)
                exp_q.push_back(int'(w[7:0]));
            frame({1'b0, w[7:0]}, 4'h8, 1'b1);
            if (i == 0)
            begin
                wait_wake();
                chk("rx wake", {15'h0000, wake}, 16'h0001);
                chk("rx irq", {15'h0000, irq}, 16'h0001);
                sleep <= 1'b0;
            end
        end
        rd_chk(8'h04, 8'h92, "overrun");
        repeat (2) rd_chk(8'h18, 8'(exp_q.pop_front()), "rx data");
        rd_chk(8'h20, 8'h00, "rx flag clear");
        wr_reg(8'h04, 8'h80);
        rd_chk(8'h04, 8'h80, "overrun clear");
        wr_reg(8'h04, 8'h00);
        // Nine-bit receive, idle-high clock
        wr_reg(8'h08, 8'h10);
        m_pol <= 1'b1;
        wr_reg(8'h04, 8'hD0);
        rnd();
        frame(w, 4'h9, 1'b1);
        rd_chk(8'h04, {7'h68, w[8]}, "ninth bit");
        rd_chk(8'h18, w[7:0], "rx data nine");
        // Slave transmit of two words, the first during sleep
        wr_reg(8'h04, 8'hA0);
        wr_reg(8'h00, 8'h30);
        wr_reg(8'h1C, 8'h06);
        rnd();
        t0 = w[7:0];
        rnd();
        t1 = w[7:0];
        wr_reg(8'h14, t0);
        repeat (3) @(posedge mclk);
        wr_reg(8'h14, t1);
        rd_chk(8'h20, 8'h00, "tx flag held");
        sleep <= 1'b1;
        chk("no early wake", {15'h0000, wake}, 16'h0000);
        frame(9'h000, 4'h8, 1'b0);
        chk("tx first", {7'h00, m_rx}, {8'h00, t0});
        wait_wake();
        chk("tx wake", {15'h0000, wake}, 16'h0001);
        chk("tx no irq", {15'h0000, irq}, 16'h0000);
        sleep <= 1'b0;
        rd_chk(8'h20, 8'h02, "tx flag set");
        frame(9'h000, 4'h8, 1'b0);
        chk("tx second", {7'h00, m_rx}, {8'h00, t1});
        // Master receive must freeze its clock in sleep
        wr_reg(8'h04, 8'h00);
        wr_reg(8'h0C, 8'h01);
        wr_reg(8'h00, 8'h90);
        wr_reg(8'h04, 8'h90);
        sleep <= 1'b1;
        repeat (20) @(posedge mclk);
        sleep <= 1'b0;
        repeat (20) @(posedge mclk);
        wr_reg(8'h04, 8'h00);
        report_and_stop();
    end
endmodule
